// ---- rtl/channel_protection_latch.sv ----
// Four-channel fault protection: shutdown, retry counting, latches, error flags
`default_nettype none
// Notes on behaviour
// - Channel switches off when current passes the normal trip level.
// - Over-current restarts are limited: 32 at low, 8 at medium voltage.
// - Error flag set on over-current shutdown, cleared on read, set again if persists.
// - Clear-latch command bit of one clears that channel's retry or thermal latch.
// - Channel still requested on after a clear turns on at once.
// - High drain-source voltage plus reduced-level current at turn-on latches off.
// - After on-time without thermal shutdown the trip level drops to reduced level.
// - Trip delay restarts on temperature-rise or over-current shutdown or request change.
// - At reduced level, current above reduced trip latches the channel off.
// - Each channel's over-temperature trips off and latches, even without logic supply.
// - Thermal latch releases only after cooling by hysteresis and a clear command.
// - Temperature-rise trip retries up to the limit, then latches off.
// - Below the limit, a rising request edge resets the retry counter.
// - Error flag set on temperature-rise shutdown, cleared on read, set again if recurs.
// - Reverse polarity turns all channels on with protection inactive.
// - Supply over-voltage below clamp keeps outputs following the request.
// - Loss of device ground forces every channel off.
// - Error flags clear during each standard diagnosis transfer.
// - First diagnosis after a clear still reports previously failed channels.
module channel_protection_latch (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Channel requests
  input wire logic [prot_pkg::NUM_CH-1:0] in_pin_in,
  input wire logic [prot_pkg::NUM_CH-1:0] output_control_bits_in,
  // Commands from the serial side
  input wire logic [prot_pkg::NUM_CH-1:0] clear_latch_cmd_in,
  input wire logic clear_latch_stb_in,
  input wire logic diag_clear_stb_in,
  // Analog comparator results
  input wire logic [prot_pkg::NUM_CH-1:0] oc_trip_in,
  input wire logic [prot_pkg::NUM_CH-1:0] oc_reduced_in,
  input wire logic [prot_pkg::NUM_CH-1:0] vds_high_in,
  input wire logic [prot_pkg::NUM_CH-1:0] vds_medium_in,
  input wire logic [prot_pkg::NUM_CH-1:0] over_temp_in,
  input wire logic [prot_pkg::NUM_CH-1:0] temp_cooled_in,
  input wire logic [prot_pkg::NUM_CH-1:0] temp_rise_in,
  // Supply conditions
  input wire logic reverse_supply_in,
  input wire logic ground_lost_in,
  // Outputs
  output logic [prot_pkg::NUM_CH-1:0] gate_on_out,
  output logic [prot_pkg::NUM_CH-1:0] err_flag_out,
  output logic [prot_pkg::NUM_CH-1:0] latched_out,
  output logic [prot_pkg::NUM_CH-1:0] thermal_latched_out
);
  import prot_pkg::*;

  // ====================================================================
  // Input synchronisation
  logic [NUM_CH-1:0] oc_s, ocr_s, vdh_s, vdm_s, ot_s, cool_s, rise_s;
  logic [1:0] sup_s;
  sync_vec #(.W(NUM_CH)) u_s_oc (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in(oc_trip_in), .q_out(oc_s));
  sync_vec #(.W(NUM_CH)) u_s_ocr (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in(oc_reduced_in), .q_out(ocr_s));
  sync_vec #(.W(NUM_CH)) u_s_vdh (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in(vds_high_in), .q_out(vdh_s));
  sync_vec #(.W(NUM_CH)) u_s_vdm (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in(vds_medium_in), .q_out(vdm_s));
  sync_vec #(.W(NUM_CH)) u_s_ot (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in(over_temp_in), .q_out(ot_s));
  sync_vec #(.W(NUM_CH)) u_s_cool (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in(temp_cooled_in), .q_out(cool_s));
  sync_vec #(.W(NUM_CH)) u_s_rise (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in(temp_rise_in), .q_out(rise_s));
  sync_vec #(.W(2)) u_s_sup (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .d_in({ground_lost_in, reverse_supply_in}), .q_out(sup_s));

  // ====================================================================
  // Request tracking
  logic [NUM_CH-1:0] req;
  logic [NUM_CH-1:0] req_prev_r;
  assign req = in_pin_in | output_control_bits_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_prev_r <= '0;
    end else begin
      req_prev_r <= req;
    end
  end

  // ====================================================================
  // Per-channel protection
  ch_state_e state_r [NUM_CH];
  logic [RETRY_W-1:0] retry_r [NUM_CH];
  logic [NUM_CH-1:0] reduced;
  logic [NUM_CH-1:0] trip_restart;
  logic [NUM_CH-1:0] shut_ev;
  logic [NUM_CH-1:0] turn_on_r;
  logic [NUM_CH-1:0] thermal_r;
  logic [NUM_CH-1:0] gate_nxt;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic [RETRY_W-1:0] lim;
      logic hard_trip;
      logic retry_trip;
      logic clr;
      // Retry limit follows drain-source voltage band
      assign lim = vdm_s[g] ? RETRY_LIM_MV : RETRY_LIM_LV;
      // Immediate latch conditions
      assign hard_trip = ot_s[g]
        || (vdh_s[g] && ocr_s[g] && turn_on_r[g])
        || (reduced[g] && ocr_s[g]);
      assign retry_trip = oc_s[g] || rise_s[g];
      // Thermal latch needs cooling before a clear is honoured
      assign clr = clear_latch_stb_in && clear_latch_cmd_in[g]
        && (!thermal_r[g] || cool_s[g]);
      assign trip_restart[g] = (req[g] != req_prev_r[g])
        || (state_r[g] == CH_RETRY);
      assign shut_ev[g] = (state_r[g] == CH_ON) && (hard_trip || retry_trip);

      trip_timer u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .run_in(state_r[g] == CH_ON && !ot_s[g]),
        .restart_in(trip_restart[g]),
        .limit_in(TRIP_CNT_W'(TRIP_DELAY_CYC)),
        .reduced_out(reduced[g])
      );

      // State machine of one channel
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          state_r[g] <= CH_OFF;
          retry_r[g] <= '0;
          thermal_r[g] <= 1'b0;
          turn_on_r[g] <= 1'b0;
        end else begin
          turn_on_r[g] <= 1'b0;
          // Rising request below the limit rearms retries
          if (req[g] && !req_prev_r[g] && retry_r[g] < lim && state_r[g] != CH_LATCHED) begin
            retry_r[g] <= '0;
          end
          unique case (state_r[g])
            CH_OFF: begin
              if (req[g]) begin
                state_r[g] <= CH_ON;
                turn_on_r[g] <= 1'b1;
              end
            end
            CH_ON: begin
              if (hard_trip) begin
                state_r[g] <= CH_LATCHED;
                thermal_r[g] <= ot_s[g];
              end else if (retry_trip) begin
                if (retry_r[g] + 1'b1 >= lim) begin
                  state_r[g] <= CH_LATCHED;
                end else begin
                  state_r[g] <= CH_RETRY;
                end
                retry_r[g] <= retry_r[g] + 1'b1;
              end else if (!req[g]) begin
                state_r[g] <= CH_OFF;
              end
            end
            CH_RETRY: begin
              // Restart once the fault indication has gone
              if (!retry_trip) begin
                state_r[g] <= req[g] ? CH_ON : CH_OFF;
                turn_on_r[g] <= req[g];
              end
            end
            CH_LATCHED: begin
              if (clr) begin
                state_r[g] <= req[g] ? CH_ON : CH_OFF;
                turn_on_r[g] <= req[g];
                retry_r[g] <= '0;
                thermal_r[g] <= 1'b0;
              end
            end
          endcase
        end
      end
    end
  endgenerate

  // ====================================================================
  // Gate drive and supply overrides
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      gate_nxt[i] = (state_r[i] == CH_ON) && !shut_ev[i] && req[i];
    end
    if (sup_s[1]) begin
      gate_nxt = CH_ZERO;
    end else if (sup_s[0]) begin
      gate_nxt = CH_ONES;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_on_out <= '0;
    end else begin
      gate_on_out <= gate_nxt;
    end
  end

  // ====================================================================
  // Error flags: sticky until the next diagnosis read
  logic [NUM_CH-1:0] err_set;
  logic [NUM_CH-1:0] lat_now;
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      lat_now[i] = (state_r[i] == CH_LATCHED);
      err_set[i] = shut_ev[i] || (state_r[i] == CH_RETRY) || lat_now[i];
    end
  end

  // A clear-latch leaves the flag up, so the first read after it still shows the fault
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      err_flag_out <= '0;
    end else begin
      if (diag_clear_stb_in) begin
        // Set wins over the read clear
        err_flag_out <= err_set;
      end else begin
        err_flag_out <= err_flag_out | err_set;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latched_out <= '0;
      thermal_latched_out <= '0;
    end else begin
      latched_out <= lat_now;
      thermal_latched_out <= thermal_r;
    end
  end

  // ====================================================================
  // Checks, one copy per channel except the two supply checks below; all are off while reset is low
  for (genvar a = 0; a < NUM_CH; a++) begin : g_chk

    // Over-temperature latches at once and keeps its cause
    a_ot_latches: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_ON && ot_s[a])
      |=> (state_r[a] == CH_LATCHED && thermal_r[a]))
      else $error("over-temperature did not latch");

    // Only a clear for this very channel may open its latch
    a_latch_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_LATCHED && !(clear_latch_stb_in && clear_latch_cmd_in[a]))
      |=> state_r[a] == CH_LATCHED)
      else $error("latch released without command");

    // A released latch goes straight back on when still requested
    a_clear_turns_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_LATCHED && clear_latch_stb_in && clear_latch_cmd_in[a]
       && (!thermal_r[a] || cool_s[a]) && req[a])
      |=> state_r[a] == CH_ON)
      else $error("cleared channel not turned on");

    // A hot channel ignores the clear until it has cooled
    a_thermal_cool: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_LATCHED && thermal_r[a] && !cool_s[a])
      |=> state_r[a] == CH_LATCHED)
      else $error("thermal latch released while hot");

    // Once the trip delay has run out, reduced-level current latches the channel
    a_reduced_trip: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_ON && reduced[a] && ocr_s[a])
      |=> state_r[a] == CH_LATCHED)
      else $error("reduced-level trip not latched");

    // High drain-source voltage trip only looks at the turn-on cycle
    a_hv_turn_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_ON && turn_on_r[a] && vdh_s[a] && ocr_s[a])
      |=> state_r[a] == CH_LATCHED)
      else $error("high-voltage turn-on trip not latched");

    // Reverse supply overrides every shutdown, so it is left out here
    a_oc_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_ON && oc_s[a] && !sup_s[0])
      |=> !gate_on_out[a])
      else $error("over-current did not switch off");
    a_rise_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_ON && rise_s[a] && !sup_s[0])
      |=> !gate_on_out[a])
      else $error("temperature rise did not switch off");
    a_retry_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_RETRY && !sup_s[0])
      |=> !gate_on_out[a])
      else $error("gate on during restart wait");
    a_latched_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_LATCHED && !sup_s[0])
      |=> !gate_on_out[a])
      else $error("gate on while latched");

    // Gate drops with the request unless reverse supply forces it on
    a_gate_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!req[a] && !sup_s[0])
      |=> !gate_on_out[a])
      else $error("gate on without a request");
    a_turn_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_OFF && req[a])
      |=> state_r[a] == CH_ON)
      else $error("requested channel not turned on");

    // Error flag: set on entering retry, kept until read, dropped by a read while off
    a_err_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $rose(state_r[a] == CH_RETRY)
      |-> err_flag_out[a])
      else $error("error flag missing on retry");
    a_err_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (err_flag_out[a] && !diag_clear_stb_in)
      |=> err_flag_out[a])
      else $error("error flag lost without a read");
    a_err_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (diag_clear_stb_in && state_r[a] == CH_OFF)
      |=> !err_flag_out[a])
      else $error("read did not clear the error flag");

    // Retry count stays below the low-voltage limit while waiting to restart
    a_retry_cap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_RETRY)
      |-> retry_r[a] < RETRY_LIM_LV)
      else $error("retry count beyond limit");

    // A band change can leave the count above the medium limit; that case is skipped
    a_retry_rearm: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (state_r[a] == CH_OFF && req[a] && !req_prev_r[a] && retry_r[a] < RETRY_LIM_MV)
      |=> retry_r[a] == '0)
      else $error("retry count not rearmed by a new request");
    a_timer_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      trip_restart[a]
      |=> !reduced[a])
      else $error("trip delay not restarted");
  end

  // Ground loss wins over reverse supply
  a_gnd_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sup_s[1]
    |=> gate_on_out == CH_ZERO)
    else $error("ground loss left a channel on");
  a_rev_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (sup_s[0] && !sup_s[1])
    |=> gate_on_out == CH_ONES)
    else $error("reverse supply did not turn all on");
endmodule // channel_protection_latch
`default_nettype wire

// ---- rtl/prot_pkg.sv ----
// Constants shared by the channel protection latch design
`default_nettype none
package prot_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CLK_HZ = 20000000;
  // Trip delay window, ms; the reduction uses the least figure
  localparam int unsigned TRIP_DELAY_MIN_MS = 7;
  localparam int unsigned TRIP_DELAY_MAX_MS = 14;
  localparam int unsigned TRIP_DELAY_CYC = (CLK_HZ / 1000) * TRIP_DELAY_MIN_MS;
  localparam int unsigned TRIP_CNT_W = 18;
  // Retry limits at low and medium drain-source voltage
  localparam logic [5:0] RETRY_LIM_LV = 6'h20;
  localparam logic [5:0] RETRY_LIM_MV = 6'h08;
  localparam int unsigned RETRY_W = 6;
  // Host wait before clearing a latch, ms (binds the host)
  localparam int unsigned LATCH_RESTART_WAIT_MS = 50;
  localparam logic [NUM_CH-1:0] CH_ZERO = 4'h0;
  localparam logic [NUM_CH-1:0] CH_ONES = 4'hF;
  // Per-channel protection state
  typedef enum logic [1:0] {
    CH_OFF = 2'b00,
    CH_ON = 2'b01,
    CH_RETRY = 2'b11,
    CH_LATCHED = 2'b10
  } ch_state_e;
endpackage : prot_pkg
`default_nettype wire

// ---- rtl/sync_vec.sv ----
// Two-flop synchroniser for a vector of comparator levels
`default_nettype none
module sync_vec #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule // sync_vec
`default_nettype wire

// ---- rtl/trip_timer.sv ----
// Per-channel trip delay timer for the reduced short-circuit threshold
`default_nettype none
module trip_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic run_in,
  input wire logic restart_in,
  input wire logic [prot_pkg::TRIP_CNT_W-1:0] limit_in,
  // Status
  output logic reduced_out
);
  import prot_pkg::*;
  logic [TRIP_CNT_W-1:0] cnt_r;
  // Count on-time; any restart or stop throws the count away
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      reduced_out <= 1'b0;
    end else if (restart_in || !run_in) begin
      cnt_r <= '0;
      reduced_out <= 1'b0;
    end else if (cnt_r >= limit_in) begin
      reduced_out <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // trip_timer
`default_nettype wire

// ---- tb/channel_protection_latch_tb_top.sv ----
// Self-checking bench for the channel protection latch
`default_nettype none
module channel_protection_latch_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import prot_pkg::*;
  // ==========================================
  // Signals
  typedef struct {logic [3:0] p, c; logic r, g; logic [3:0] e;} row_s;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] pin = 4'h0, oc = 4'h0, ocr = 4'h0, vh = 4'h0, vm = 4'h0;
  logic [3:0] ot = 4'h0, cool = 4'h0, rise = 4'h0;
  logic rev = 1'b0, gnd = 1'b0;
  logic [3:0] ctl, cmd, gate, err, lat, tlat;
  logic cstb, dstb;
  int fails = 0;
  int comparisons = 0;
  // Request pin, request bits, reverse, ground lost, expected gates
  row_s rows [5] = '{'{4'h1, 4'h0, 1'b0, 1'b0, 4'h1}, '{4'h0, 4'hA, 1'b0, 1'b0, 4'hA},
    '{4'h5, 4'hA, 1'b0, 1'b0, 4'hF}, '{4'hF, 4'h0, 1'b0, 1'b1, 4'h0},
    '{4'h0, 4'h0, 1'b1, 1'b0, 4'hF}};
  // ==========================================
  // Clock, design and host
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  channel_protection_latch uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .in_pin_in(pin),
    .output_control_bits_in(ctl), .clear_latch_cmd_in(cmd), .clear_latch_stb_in(cstb),
    .diag_clear_stb_in(dstb), .oc_trip_in(oc), .oc_reduced_in(ocr), .vds_high_in(vh),
    .vds_medium_in(vm), .over_temp_in(ot), .temp_cooled_in(cool), .temp_rise_in(rise),
    .reverse_supply_in(rev), .ground_lost_in(gnd), .gate_on_out(gate), .err_flag_out(err),
    .latched_out(lat), .thermal_latched_out(tlat));
  host_model host (.clk_in(clk_in), .ctl_out(ctl), .clr_cmd_out(cmd), .clr_stb_out(cstb),
    .diag_stb_out(dstb));
  // ==========================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Sample a little after the edge so its updates have landed
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    #1;
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Transient trip: oc when r is 0, temperature rise when r is 1
  task automatic pulse(input bit r, input logic [3:0] m);
    tick(1);
    if (r) begin
      rise <= m;
    end else begin
      oc <= m;
    end
    tick(4);
    chk(gate & m, 4'h0);
    tick(1);
    rise <= 4'h0;
    oc <= 4'h0;
    tick(8);
  endtask
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // Watchdog, far beyond the nine hundred or so cycles the tests need
  initial begin
    tick(20000);
    fails++;
    stop_test();
  end
  // ==========================================
  // Tests
  initial begin
    tick(4);
    chk(gate | err | lat | tlat, 4'h0);
    tick(4);
    rst_n_in <= 1'b1;
    tick(3);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      pin <= rows[i].p;
      host.set_ctl(rows[i].c);
      rev <= rows[i].r;
      gnd <= rows[i].g;
      tick(6);
      chk(gate, rows[i].e);
      tick(1);
    end
    pin <= 4'h1;
    host.set_ctl(4'h0);
    rev <= 1'b0;
    gnd <= 1'b0;
    $display("test table done");
    // Over-temperature latch, refused clear while hot, then release
    tick(6);
    ot <= 4'h1;
    tick(6);
    chk({gate[0], lat[0], tlat[0], err[0]}, 4'h7);
    tick(1);
    ot <= 4'h0;
    host.clear(4'h1);
    tick(4);
    chk(lat, 4'h1);
    tick(1);
    cool <= 4'h1;
    host.clear(4'h1);
    tick(3);
    chk({gate, lat}, 8'h10);
    chk(err, 4'h1);
    host.diag();
    tick(2);
    chk(err, 4'h0);
    tick(1);
    cool <= 4'h0;
    pin <= 4'h2;
    vm <= 4'h2;
    $display("test thermal done");
    // Over-current retries at medium voltage, counter reset by a new request
    tick(6);
    repeat (7) pulse(1'b0, 4'h2);
    chk({lat, err}, 8'h02);
    host.diag();
    tick(2);
    chk(err, 4'h0);
    tick(1);
    pin <= 4'h0;
    tick(4);
    pin <= 4'h2;
    tick(6);
    repeat (7) pulse(1'b0, 4'h2);
    chk(lat, 4'h0);
    pulse(1'b0, 4'h2);
    chk(lat, 4'h2);
    pulse(1'b0, 4'h2);
    chk({gate, lat}, 8'h02);
    host.clear(4'h2);
    tick(3);
    chk({gate, lat}, 8'h20);
    tick(1);
    vm <= 4'h0;
    pin <= 4'h4;
    $display("test over current done");
    // Temperature-rise retries at low voltage
    tick(6);
    repeat (31) pulse(1'b1, 4'h4);
    chk({lat, err & 4'h4}, 8'h04);
    pulse(1'b1, 4'h4);
    chk(lat, 4'h4);
    pulse(1'b1, 4'h4);
    chk(lat, 4'h4);
    host.clear(4'h4);
    tick(1);
    pin <= 4'h0;
    vh <= 4'h8;
    ocr <= 4'h8;
    $display("test temperature rise done");
    // High drain-source voltage trip at turn-on
    tick(4);
    pin <= 4'h8;
    tick(6);
    chk({gate, lat}, 8'h08);
    $display("test high voltage done");
    // Reset in mid-run drops latch and flags; a held request comes back
    tick(1);
    rst_n_in <= 1'b0;
    vh <= 4'h0;
    ocr <= 4'h0;
    tick(2);
    chk({gate | err, lat | tlat}, 8'h00);
    tick(1);
    rst_n_in <= 1'b1;
    tick(4);
    chk({gate, lat}, 8'h80);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule // channel_protection_latch_tb_top
`default_nettype wire

// ---- tb/host_model.sv ----
// Host side model: request bits, clear-latch and diagnosis commands
`default_nettype none
module host_model #(
  // Restart wait, scaled down from 50 ms to keep the run short
  parameter int unsigned WAIT_CYC = 20
) (
  // Clock
  input wire logic clk_in,
  // Commands to the device
  output logic [prot_pkg::NUM_CH-1:0] ctl_out,
  output logic [prot_pkg::NUM_CH-1:0] clr_cmd_out,
  output logic clr_stb_out,
  output logic diag_stb_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import prot_pkg::*;
  // ==========================================
  // Idle levels
  initial begin
    ctl_out = CH_ZERO;
    clr_cmd_out = CH_ZERO;
    clr_stb_out = 1'b0;
    diag_stb_out = 1'b0;
  end
  // Request bits change at once, caller is on an edge
  task automatic set_ctl(input logic [NUM_CH-1:0] v);
    ctl_out <= v;
  endtask
  // Clear after the restart wait; bits are junk outside the strobe
  task automatic clear(input logic [NUM_CH-1:0] m);
    repeat (WAIT_CYC) @(posedge clk_in);
    clr_cmd_out <= m;
    clr_stb_out <= 1'b1;
    @(posedge clk_in);
    clr_stb_out <= 1'b0;
    clr_cmd_out <= ~m;
  endtask
  // One diagnosis transfer
  task automatic diag();
    @(posedge clk_in);
    diag_stb_out <= 1'b1;
    @(posedge clk_in);
    diag_stb_out <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire
